// [fibuc_pkg.sv]
// Package: constants and carriers for the flash upgrade controller
//------------------------------------------------------------------
// Behaviour
//------------------------------------------------------------------
package fibuc_pkg;
    //--------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int WRITE_NS = 23500;
    localparam int ERASE_BASE_US = 570;
    localparam int ERASE_STEP_US = 500;
    localparam int ERASE_MAX_US = 4570;
    localparam int WRITE_CYC = WRITE_NS / 50;
    localparam int ERASE_BASE_CYC = ERASE_BASE_US * 20;
    localparam int ERASE_STEP_CYC = ERASE_STEP_US * 20;
    localparam int ERASE_MAX_CYC = ERASE_MAX_US * 20;
    localparam int CNT_W = 17;
    localparam logic [4:0] ERASE_LIMIT = 5'h09;
    //--------------------------------------------------------------
    // Commands and sequences
    //--------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE = 8'h96;
    localparam logic [7:0] CMD_WRITE = 8'h69;
    localparam logic [39:0] SEQ_ENTER = 40'h123456789A;
    localparam logic [39:0] SEQ_EXIT = 40'hFEDCBA9876;
    localparam logic [39:0] SEQ_APP = 40'hFF008855AA;
    localparam logic [39:0] SEQ_BOOT = 40'h37C8429A65;
    //--------------------------------------------------------------
    // Boot sizes and offsets
    //--------------------------------------------------------------
    localparam logic [1:0] BOOT_NONE = 2'h3;
    localparam logic [15:0] OFS_ZERO = 16'h0000;
    localparam logic [15:0] OFS_2K = 16'h0800;
    localparam logic [15:0] OFS_4K = 16'h1000;
    localparam logic [15:0] OFS_8K = 16'h2000;
    localparam logic [6:0] BLK_FIRST = 7'h04;
    localparam logic [6:0] BLK_LAST = 7'h7D;
    localparam logic [7:0] TIM_RESET = 8'hDD;

    typedef enum logic [1:0] {
        FIBUC_IDLE,
        FIBUC_ERASE,
        FIBUC_WRITE
    } fibuc_op_e;

    typedef struct packed {
        logic [7:0] addr_high;
        logic [7:0] addr_low;
        logic [7:0] data;
    } fibuc_req_s;

    typedef struct packed {
        logic [2:0] cnt;
        logic done;
    } fibuc_seq_s;
endpackage

// [fibuc_seq_match.sv]
// Module: five-byte ordered unlock sequence matcher
`timescale 1ns/10ps
module fibuc_seq_match #(
    parameter logic [39:0] SEQ = 40'h0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [7:0] i_byte,
    output logic o_hit
);
    fibuc_pkg::fibuc_seq_s st_q;
    fibuc_pkg::fibuc_seq_s st_d;
    logic [7:0] expect_b;

    always_comb begin
        expect_b = SEQ[39 - 8 * st_q.cnt -: 8];
        st_d = st_q;
        st_d.done = 1'b0;
        if (i_wr) begin
            // Wrong byte restarts; it may itself be a first byte
            if (i_byte == expect_b) begin
                if (st_q.cnt == 3'h4) begin
                    st_d.cnt = 3'h0;
                    st_d.done = 1'b1;
                end else begin
                    st_d.cnt = st_q.cnt + 3'h1;
                end
            end else if (i_byte == SEQ[39:32]) begin
                st_d.cnt = 3'h1;
            end else begin
                st_d.cnt = 3'h0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_hit = st_q.done;

    property p_seq_hit;
        @(posedge i_clk) disable iff (i_rst)
        o_hit |-> $past(i_wr) && $past(i_byte) == SEQ[7:0];
    endproperty
    a_seq_hit: assert property (p_seq_hit)
        else $error("sequence hit without last byte");
endmodule

// [fibuc_top.sv]
// Module: flash upgrade, space jump, page erase and byte write sequencer
`timescale 1ns/10ps
module fibuc_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_boot_size_sel,
    input wire logic i_addr_high_wr,
    input wire logic i_addr_low_wr,
    input wire logic i_write_byte_wr,
    input wire logic i_command_wr,
    input wire logic i_timing_wr,
    input wire logic i_jump_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [15:0] i_pc,
    input wire logic i_flash_ready,
    output logic o_upgrade_mode,
    output logic o_in_app_space,
    output logic [15:0] o_code_offset,
    output logic [15:0] o_fetch_addr,
    output logic [7:0] o_flash_addr_high,
    output logic [7:0] o_flash_addr_low,
    output logic [7:0] o_flash_write_byte,
    output logic [7:0] o_flash_command,
    output logic [7:0] o_flash_timing_ctrl,
    output logic [7:0] o_jump_last,
    output logic o_cpu_clk_en,
    output logic o_flash_erase,
    output logic o_flash_write,
    output logic [15:0] o_flash_addr,
    output logic [7:0] o_flash_data,
    output logic o_busy
);
    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    typedef struct packed {
        fibuc_pkg::fibuc_req_s req;
        logic [7:0] cmd;
        logic [7:0] tim;
        logic [7:0] jump;
        logic upg;
        logic app;
        fibuc_pkg::fibuc_op_e op;
        logic [fibuc_pkg::CNT_W-1:0] cnt;
        logic [15:0] paddr;
        logic [7:0] pdata;
    } fibuc_st_s;

    fibuc_st_s st_q;
    fibuc_st_s st_d;
    logic hit_enter;
    logic hit_exit;
    logic hit_app;
    logic hit_boot;
    logic [15:0] boot_ofs;
    logic [6:0] blk;
    logic protect;
    logic [fibuc_pkg::CNT_W-1:0] erase_cyc;

    //--------------------------------------------------------------
    // Sequence matchers
    //--------------------------------------------------------------
    fibuc_seq_match #(.SEQ(fibuc_pkg::SEQ_ENTER)) u_enter (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_command_wr),
        .i_byte(i_wdata), .o_hit(hit_enter));
    fibuc_seq_match #(.SEQ(fibuc_pkg::SEQ_EXIT)) u_exit (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_command_wr),
        .i_byte(i_wdata), .o_hit(hit_exit));
    fibuc_seq_match #(.SEQ(fibuc_pkg::SEQ_APP)) u_app (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_jump_wr),
        .i_byte(i_wdata), .o_hit(hit_app));
    fibuc_seq_match #(.SEQ(fibuc_pkg::SEQ_BOOT)) u_boot (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr(i_jump_wr),
        .i_byte(i_wdata), .o_hit(hit_boot));

    //--------------------------------------------------------------
    // Boot area size and protection
    //--------------------------------------------------------------
    always_comb begin
        case (i_boot_size_sel)
            2'h0: boot_ofs = fibuc_pkg::OFS_2K;
            2'h1: boot_ofs = fibuc_pkg::OFS_4K;
            2'h2: boot_ofs = fibuc_pkg::OFS_8K;
            default: boot_ofs = fibuc_pkg::OFS_ZERO;
        endcase
    end

    always_comb begin
        // Timing field above nine saturates at the long erase
        if (st_q.tim[4:0] > fibuc_pkg::ERASE_LIMIT) begin
            erase_cyc = fibuc_pkg::CNT_W'(fibuc_pkg::ERASE_MAX_CYC);
        end else begin
            erase_cyc = fibuc_pkg::CNT_W'(fibuc_pkg::ERASE_BASE_CYC
                + fibuc_pkg::ERASE_STEP_CYC * int'(st_q.tim[4:0]));
        end
    end

    assign blk = st_q.req.addr_high[7:1];
    // Boot area covers offsets below its size; also guard data area
    assign protect = ({blk, 9'h000} < boot_ofs)
        || (blk < fibuc_pkg::BLK_FIRST) || (blk > fibuc_pkg::BLK_LAST);

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (i_addr_high_wr) begin
            st_d.req.addr_high = i_wdata;
        end
        if (i_addr_low_wr) begin
            st_d.req.addr_low = i_wdata;
        end
        if (i_write_byte_wr) begin
            st_d.req.data = i_wdata;
        end
        if (i_timing_wr) begin
            st_d.tim = i_wdata;
        end
        if (i_jump_wr) begin
            st_d.jump = i_wdata;
        end
        if (i_command_wr) begin
            st_d.cmd = i_wdata;
        end
        // Entry only from boot space with boot function present
        if (hit_enter && i_boot_size_sel != fibuc_pkg::BOOT_NONE
            && !st_q.app) begin
            st_d.upg = 1'b1;
        end
        if (hit_exit) begin
            st_d.upg = 1'b0;
        end
        if (hit_app && i_boot_size_sel != fibuc_pkg::BOOT_NONE) begin
            st_d.app = 1'b1;
        end
        if (hit_boot) begin
            st_d.app = 1'b0;
        end
        case (st_q.op)
            fibuc_pkg::FIBUC_IDLE: begin
                if (i_command_wr && st_q.upg && !protect) begin
                    if (i_wdata == fibuc_pkg::CMD_ERASE) begin
                        st_d.op = fibuc_pkg::FIBUC_ERASE;
                        st_d.cnt = erase_cyc;
                        st_d.paddr = {blk, 9'h000};
                    end else if (i_wdata == fibuc_pkg::CMD_WRITE) begin
                        st_d.op = fibuc_pkg::FIBUC_WRITE;
                        st_d.cnt = fibuc_pkg::CNT_W'(fibuc_pkg::WRITE_CYC);
                        st_d.paddr = {st_q.req.addr_high,
                            st_q.req.addr_low};
                        st_d.pdata = st_q.req.data;
                    end
                end
            end
            fibuc_pkg::FIBUC_ERASE, fibuc_pkg::FIBUC_WRITE: begin
                // Hold time counts only while flash reports ready
                if (st_q.cnt > fibuc_pkg::CNT_W'(1)) begin
                    if (i_flash_ready) begin
                        st_d.cnt = st_q.cnt - fibuc_pkg::CNT_W'(1);
                    end
                end else begin
                    st_d.op = fibuc_pkg::FIBUC_IDLE;
                    st_d.cnt = '0;
                end
            end
            default: st_d.op = fibuc_pkg::FIBUC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= '0;
            st_q.tim <= fibuc_pkg::TIM_RESET;
            st_q.op <= fibuc_pkg::FIBUC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    always_comb begin
        if (i_boot_size_sel == fibuc_pkg::BOOT_NONE) begin
            o_code_offset = fibuc_pkg::OFS_ZERO;
        end else if (st_q.app) begin
            o_code_offset = boot_ofs;
        end else begin
            o_code_offset = fibuc_pkg::OFS_ZERO;
        end
    end

    assign o_fetch_addr = i_pc + o_code_offset;
    assign o_upgrade_mode = st_q.upg;
    assign o_in_app_space = st_q.app;
    assign o_flash_addr_high = st_q.req.addr_high;
    assign o_flash_addr_low = st_q.req.addr_low;
    assign o_flash_write_byte = st_q.req.data;
    assign o_flash_command = st_q.cmd;
    assign o_flash_timing_ctrl = st_q.tim;
    assign o_jump_last = st_q.jump;
    assign o_busy = st_q.op != fibuc_pkg::FIBUC_IDLE;
    assign o_cpu_clk_en = !o_busy;
    assign o_flash_erase = st_q.op == fibuc_pkg::FIBUC_ERASE;
    assign o_flash_write = st_q.op == fibuc_pkg::FIBUC_WRITE;
    assign o_flash_addr = st_q.paddr;
    assign o_flash_data = st_q.pdata;

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    sequence s_write_go;
        $rose(o_flash_write);
    endsequence

    property p_write_len;
        @(posedge i_clk) disable iff (i_rst)
        s_write_go ##0 i_flash_ready [*8] |-> o_flash_write;
    endproperty
    a_write_len: assert property (p_write_len)
        else $error("byte write ended early");

    property p_erase_gate;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_flash_erase) |-> $past(st_q.upg); 
    endproperty
    a_erase_gate: assert property (p_erase_gate)
        else $error("erase started outside upgrade mode");

    // Accepted command: legal page, upgrade on, no operation running
    sequence s_op_req;
        i_command_wr && o_upgrade_mode && !protect && !o_busy
        && (i_wdata == fibuc_pkg::CMD_ERASE
        || i_wdata == fibuc_pkg::CMD_WRITE);
    endsequence

    property p_clk_stop;
        @(posedge i_clk) disable iff (i_rst)
        s_op_req |=> !o_cpu_clk_en && o_busy;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("cpu clock running during flash operation");

    property p_enter;
        @(posedge i_clk) disable iff (i_rst)
        hit_enter && i_boot_size_sel != fibuc_pkg::BOOT_NONE && !st_q.app
        && !hit_exit |=> o_upgrade_mode;
    endproperty
    a_enter: assert property (p_enter)
        else $error("upgrade mode not entered");

    property p_exit;
        @(posedge i_clk) disable iff (i_rst)
        hit_exit |=> !o_upgrade_mode;
    endproperty
    a_exit: assert property (p_exit)
        else $error("upgrade mode not left");

    property p_app;
        @(posedge i_clk) disable iff (i_rst)
        hit_app && !hit_boot && i_boot_size_sel != fibuc_pkg::BOOT_NONE
        |=> o_in_app_space;
    endproperty
    a_app: assert property (p_app)
        else $error("application jump lost");

    property p_boot;
        @(posedge i_clk) disable iff (i_rst)
        hit_boot |=> !o_in_app_space;
    endproperty
    a_boot: assert property (p_boot)
        else $error("boot jump lost");

    property p_none;
        @(posedge i_clk) disable iff (i_rst)
        i_boot_size_sel == fibuc_pkg::BOOT_NONE |-> o_code_offset == 16'h0000;
    endproperty
    a_none: assert property (p_none)
        else $error("offset nonzero without boot function");

    property p_protect;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_busy) |-> o_flash_addr >= boot_ofs;
    endproperty
    a_protect: assert property (p_protect)
        else $error("boot area operation not blocked");

    property p_refuse;
        @(posedge i_clk) disable iff (i_rst)
        !o_upgrade_mode && (o_in_app_space
        || i_boot_size_sel == fibuc_pkg::BOOT_NONE) |=> !o_upgrade_mode;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("upgrade entry not refused");

    property p_write_addr;
        @(posedge i_clk) disable iff (i_rst)
        s_write_go |-> o_flash_addr
            == $past({o_flash_addr_high, o_flash_addr_low});
    endproperty
    a_write_addr: assert property (p_write_addr)
        else $error("byte write address not high over low");

    property p_erase_page;
        @(posedge i_clk) disable iff (i_rst)
        $rose(o_flash_erase) |-> o_flash_addr[8:0] == 9'h000
            && o_flash_addr[15:9] == $past(o_flash_addr_high[7:1]);
    endproperty
    a_erase_page: assert property (p_erase_page)
        else $error("erase address not block aligned");
endmodule

// [fibuc_flash_model.sv]
// Flash array model answering the controller's erase and write levels
`timescale 1ns/10ps
module fibuc_flash_model #(
    parameter int STALL = 20
) (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_erase,
    input wire logic i_write,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_data,
    output logic o_ready
);
    logic [7:0] mem [0:65535];
    logic op_q;
    int wait_q;

    //--------------------------------------------------------------
    // Array behaviour
    //--------------------------------------------------------------
    // Slow mode holds the timer off for STALL cycles of each operation
    assign o_ready = !(i_slow && (i_erase || i_write) && wait_q < STALL);

    initial begin
        op_q = 1'b0;
        wait_q = 0;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end

    always @(posedge i_clk) begin
        op_q <= i_erase || i_write;
        wait_q <= (i_erase || i_write) ? wait_q + 1 : 0;
        if (i_write && !op_q) begin
            mem[i_addr] <= i_data;
        end
        if (i_erase && !op_q) begin
            for (int i = 0; i < 512; i++) begin
                mem[{i_addr[15:9], 9'h000} + i] <= 8'hFF;
            end
        end
    end
endmodule

// [test_fibuc_top.sv]
// Self-checking bench for the flash upgrade and space jump sequencer
`timescale 1ns/10ps
module test_fibuc_top;
    localparam int AH = 0, AL = 1, DAT = 2, CMD = 3, TIM = 4, JMP = 5;
    logic i_clk, i_rst, i_slow;
    logic [1:0] sel;
    logic [5:0] stb;
    logic [7:0] wdata, cmd_rb, tim_rb, jump_rb, fdata, fah, fal, fwb;
    logic [15:0] pc, ofs, fetch, faddr;
    logic ready, upg, app, clk_en, ers, wrt, busy;
    int n_errors, total_checks;

    fibuc_top fibuc_top_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_boot_size_sel(sel),
        .i_addr_high_wr(stb[0]), .i_addr_low_wr(stb[1]),
        .i_write_byte_wr(stb[2]), .i_command_wr(stb[3]),
        .i_timing_wr(stb[4]), .i_jump_wr(stb[5]), .i_wdata(wdata),
        .i_pc(pc), .i_flash_ready(ready), .o_upgrade_mode(upg),
        .o_in_app_space(app), .o_code_offset(ofs), .o_fetch_addr(fetch),
        .o_flash_addr_high(fah), .o_flash_addr_low(fal),
        .o_flash_write_byte(fwb),
        .o_flash_command(cmd_rb), .o_flash_timing_ctrl(tim_rb),
        .o_jump_last(jump_rb), .o_cpu_clk_en(clk_en), .o_flash_erase(ers),
        .o_flash_write(wrt), .o_flash_addr(faddr), .o_flash_data(fdata),
        .o_busy(busy)
    );

    fibuc_flash_model fibuc_flash_model_inst (
        .i_clk(i_clk), .i_slow(i_slow), .i_erase(ers), .i_write(wrt),
        .i_addr(faddr), .i_data(fdata), .o_ready(ready)
    );

    //--------------------------------------------------------------
    // Access tasks
    //--------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // One idle cycle between strobes keeps each write a clean pulse
    task automatic wr(input int r, input logic [7:0] d);
        cyc(1);
        stb[r] = 1'b1;
        wdata = d;
        cyc(1);
        stb = 6'h00;
    endtask

    task automatic seq5(input int r, input logic [39:0] s);
        for (int i = 4; i >= 0; i--) begin
            wr(r, s[8*i +: 8]);
        end
    endtask

    task automatic addr(input logic [7:0] h, input logic [7:0] l);
        wr(AH, h);
        wr(AL, l);
    endtask

    // Zero length means the command must be refused
    task automatic op(input logic [7:0] c, input int len, input logic e,
                      input logic [15:0] a);
        int n;
        logic [3:0] exp;
        n = 0;
        wr(CMD, c);
        chk(cmd_rb, c);
        for (int k = 0; k < 3 && busy !== 1'b1; k++) begin
            cyc(1);
        end
        exp = (len == 0) ? 4'b0100 : {2'b10, e, !e};
        chk({busy, clk_en, ers, wrt}, exp);
        if (len != 0) begin
            chk(faddr, a);
        end
        while (busy === 1'b1 && n < 100000) begin
            n++;
            cyc(1);
        end
        chk(16'(n), 16'(len));
        chk(clk_en, 1'b1);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    //--------------------------------------------------------------
    // Clock and watchdog
    //--------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // About one and a half times the expected run length
    initial begin
        #4000000;
        n_errors++;
        report_and_stop();
    end

    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    initial begin
        n_errors = 0;
        total_checks = 0;
        i_rst = 1'b1;
        i_slow = 1'b0;
        sel = 2'h0;
        stb = 6'h00;
        wdata = 8'h00;
        pc = 16'h0123;
        cyc(2);
        i_rst = 1'b0;
        chk({upg, app, clk_en, busy}, 4'b0010);
        chk(tim_rb, 8'hDD);
        for (int s = 0; s < 4; s++) begin
            sel = 2'(s);
            cyc(1);
            chk(ofs, 16'h0000);
            chk(fetch, 16'h0123);
        end
        seq5(CMD, 40'h123456789A);
        cyc(2);
        chk(upg, 1'b0);
        sel = 2'h0;
        addr(8'h12, 8'h00);
        op(8'h96, 0, 1'b1, 16'h0000);
        seq5(CMD, 40'h123400789A);
        cyc(2);
        chk(upg, 1'b0);
        wr(CMD, 8'h12);
        seq5(CMD, 40'h123456789A);
        cyc(2);
        chk(upg, 1'b1);
        wr(TIM, 8'h01);
        chk(tim_rb, 8'h01);
        addr(8'h12, 8'h00);
        op(8'h96, 21400, 1'b1, 16'h1200);
        addr(8'h12, 8'h34);
        chk({fah, fal}, 16'h1234);
        wr(DAT, 8'hA5);
        chk(fwb, 8'hA5);
        op(8'h69, 470, 1'b0, 16'h1234);
        chk(fdata, 8'hA5);
        chk(fibuc_flash_model_inst.mem[16'h1234], 8'hA5);
        chk(fibuc_flash_model_inst.mem[16'h13FF], 8'hFF);
        chk(fibuc_flash_model_inst.mem[16'h1400], 8'h00);
        wr(TIM, 8'h00);
        addr(8'hFA, 8'h00);
        op(8'h96, 11400, 1'b1, 16'hFA00);
        addr(8'hFC, 8'h00);
        op(8'h96, 0, 1'b1, 16'h0000);
        addr(8'h06, 8'h00);
        op(8'h69, 0, 1'b0, 16'h0000);
        sel = 2'h1;
        addr(8'h0C, 8'h10);
        op(8'h69, 0, 1'b0, 16'h0000);
        sel = 2'h2;
        addr(8'h1F, 8'hFF);
        op(8'h69, 0, 1'b0, 16'h0000);
        i_slow = 1'b1;
        addr(8'h20, 8'h00);
        op(8'h69, 490, 1'b0, 16'h2000);
        i_slow = 1'b0;
        addr(8'h00, 8'h00);
        chk({fah, fal}, 16'h0000);
        // Long erase is cut by a mid-run reset to keep the run short
        wr(TIM, 8'h0A);
        addr(8'h20, 8'h00);
        wr(CMD, 8'h96);
        cyc(21500);
        chk({busy, clk_en, ers}, 3'b101);
        i_rst = 1'b1;
        cyc(2);
        i_rst = 1'b0;
        chk({upg, app, clk_en, busy, ers}, 5'b00100);
        chk(tim_rb, 8'hDD);
        seq5(CMD, 40'h123456789A);
        cyc(2);
        chk(upg, 1'b1);
        sel = 2'h0;
        seq5(CMD, 40'hFEDCBA9876);
        cyc(2);
        chk(upg, 1'b0);
        addr(8'h12, 8'h00);
        op(8'h96, 0, 1'b1, 16'h0000);
        seq5(JMP, 40'hFF0088AA55);
        cyc(2);
        chk(app, 1'b0);
        seq5(JMP, 40'hFF008855AA);
        cyc(2);
        chk({app, jump_rb}, 9'h1AA);
        for (int s = 0; s < 3; s++) begin
            sel = 2'(s);
            cyc(1);
            chk(ofs, 16'h0800 << s);
            chk(fetch, 16'h0123 + (16'h0800 << s));
        end
        pc = 16'h4000 - 16'h2000;
        cyc(1);
        chk(fetch, 16'h4000);
        pc = 16'h0123;
        sel = 2'h3;
        cyc(1);
        chk(ofs, 16'h0000);
        sel = 2'h0;
        seq5(CMD, 40'h123456789A);
        cyc(2);
        chk(upg, 1'b0);
        seq5(JMP, 40'h37C8429A65);
        cyc(2);
        chk({app, ofs}, 17'h00000);
        sel = 2'h3;
        seq5(JMP, 40'hFF008855AA);
        cyc(2);
        chk({app, ofs}, 17'h00000);
        report_and_stop();
    end
endmodule
